/* core/exc_entry_ctrl.sv */
// Interrupt acceptance and exception entry context switch.
// Assumes the pipeline holds a valid next address and retires one
// instruction at most per cycle; the controller drives level requests.
`timescale 1ns/1ps
module exc_entry_ctrl
   import exc_entry_pkg::*;
(
   input wire logic mclk,                        // Core clock
   input wire logic arst_n,                      // Async reset, active low
   input wire logic [31:0] pendingLevels,        // Pending levels from ctrl
   input wire logic maskWr,                      // Level mask write strobe
   input wire logic [31:0] maskWrData,           // Level mask write data
   input wire exc_entry_pkg::shortcut_t shortcut, // Shortcut writes
   input wire logic msWr,                        // Full machine state write
   input wire logic [31:0] msWrData,             // Machine state write data
   input wire logic rfi,                         // Return from interrupt
   input wire logic [31:0] nextPc,               // Next instruction address
   input wire exc_entry_pkg::exc_req_t excReq,   // Other exception request
   input wire logic scrWr,                       // Scratch write strobe
   input wire logic [1:0] scrWrSel,              // Scratch write select
   input wire logic [31:0] scrWrData,            // Scratch write data
   input wire logic [1:0] scrRdSel,              // Scratch read select
   output logic [31:0] scrRdData,                // Scratch read data
   output logic [31:0] levelEnableMask,          // Level enable mask
   output logic [31:0] activeLevelView,          // Pending AND mask
   output logic [31:0] machineState,             // Machine state register
   output logic extIntEnable,                    // External enable bit
   output logic recoverable,                     // Recoverable bit
   output logic [31:0] savedReturnAddr,          // Saved return address
   output logic [31:0] savedMachineState,        // Saved machine state
   output logic [31:0] dataFaultAddr,            // Data fault address
   output logic [31:0] faultCause,               // Fault cause register
   output logic intTaken,                        // Interrupt entry pulse
   output exc_entry_pkg::redirect_t redirect     // Fetch redirect, registered
);
   logic [31:0] mask_q, mask_d;
   logic [31:0] ms_q, ms_d;
   logic [31:0] retPc_q, retPc_d;
   logic [31:0] savedMs_q, savedMs_d;
   logic [31:0] faultAddr_q, faultAddr_d;
   logic [31:0] cause_q, cause_d;
   redirect_t redir_q, redir_d;
   logic [31:0] active;
   logic intReq;
   logic enter;
   exc_kind_t kind;
   logic [31:0] vecBase;
   logic [31:0] vecOfs;

   // Active view and interrupt request; reset clears mask and enable
   assign active = pendingLevels & mask_q;
   assign intReq = ms_q[MS_EXTEN_POS] && (|active);

   // Other exceptions win over interrupts and ignore the enable bit
   always_comb begin
      kind = EXC_NONE;
      enter = 1'b0;
      vecOfs = VEC_OFS_INTR;
      if (excReq.valid) begin
         enter = 1'b1;
         vecOfs = excReq.vecOfs;
      end else if (intReq) begin
         enter = 1'b1;
         kind = EXC_INTR;
         vecOfs = VEC_OFS_INTR;
      end
   end

   // Vector base follows the base select bit of the machine state
   assign vecBase = ms_q[MS_IP_POS] ? VEC_BASE_HIGH : VEC_BASE_LOW;

   // Level enable mask
   always_comb begin
      mask_d = mask_q;
      if (maskWr) begin
         mask_d = maskWrData;
      end
   end

   // Machine state: entry takes priority over any software write
   // in the same cycle, since the instruction is not retired.
   always_comb begin
      ms_d = ms_q;
      if (enter) begin
         ms_d[MS_EXTEN_POS] = 1'b0;
         ms_d[MS_PROB_POS] = 1'b0;
         ms_d[MS_RECOV_POS] = 1'b0;
      end else if (rfi) begin
         ms_d = savedMs_q;
      end else if (msWr) begin
         ms_d = msWrData;
      end else if (shortcut.enableWr) begin
         ms_d[MS_EXTEN_POS] = 1'b1;
         ms_d[MS_RECOV_POS] = 1'b1;
      end else if (shortcut.recovOnlyWr) begin
         ms_d[MS_EXTEN_POS] = 1'b0;
         ms_d[MS_RECOV_POS] = 1'b1;
      end else if (shortcut.unrecovWr) begin
         ms_d[MS_RECOV_POS] = 1'b0;
      end
   end

   // Saved state: return address and machine state always overwritten by a new entry
   always_comb begin
      retPc_d = retPc_q;
      savedMs_d = savedMs_q;
      faultAddr_d = faultAddr_q;
      cause_d = cause_q;
      redir_d = '0;
      if (enter) begin
         retPc_d = nextPc;
         savedMs_d = ms_q;
         redir_d.valid = 1'b1;
         redir_d.target = vecBase | vecOfs;
         if (kind == EXC_NONE && excReq.faultUpd) begin
            faultAddr_d = excReq.faultAddr;
            cause_d = excReq.faultCause;
         end
      end
   end

   // State registers; reset leaves everything disabled
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mask_q <= MASK_RESET;
         ms_q <= MS_RESET;
         retPc_q <= WORD_RESET;
         savedMs_q <= WORD_RESET;
         faultAddr_q <= WORD_RESET;
         cause_q <= WORD_RESET;
         redir_q <= '0;
      end else begin
         mask_q <= mask_d;
         ms_q <= ms_d;
         retPc_q <= retPc_d;
         savedMs_q <= savedMs_d;
         faultAddr_q <= faultAddr_d;
         cause_q <= cause_d;
         redir_q <= redir_d;
      end
   end

   // Scratch words for the handler
   scratch_regs u_scratch (
      .mclk(mclk),
      .arst_n(arst_n),
      .wrEn(scrWr),
      .wrSel(scrWrSel),
      .wrData(scrWrData),
      .rdSel(scrRdSel),
      .rdData(scrRdData)
   );

   assign levelEnableMask = mask_q;
   assign activeLevelView = active;
   assign machineState = ms_q;
   assign extIntEnable = ms_q[MS_EXTEN_POS];
   assign recoverable = ms_q[MS_RECOV_POS];
   assign savedReturnAddr = retPc_q;
   assign savedMachineState = savedMs_q;
   assign dataFaultAddr = faultAddr_q;
   assign faultCause = cause_q;
   assign intTaken = enter && (kind == EXC_INTR); // Combinational strobe
   assign redirect = redir_q;
endmodule // exc_entry_ctrl

/* core/scratch_regs.sv */
// Four scratch words for handler temporary storage.
// Assumes single-cycle writes from the special register move path.
`timescale 1ns/1ps
module scratch_regs
   import exc_entry_pkg::*;
(
   input wire logic mclk,                 // Core clock
   input wire logic arst_n,               // Async reset, active low
   input wire logic wrEn,                 // Write strobe
   input wire logic [1:0] wrSel,          // Word select
   input wire logic [31:0] wrData,        // Write data
   input wire logic [1:0] rdSel,          // Read select
   output logic [31:0] rdData             // Read data, registered
);
   logic [31:0] word_q [NUM_SCRATCH];
   logic [31:0] word_d [NUM_SCRATCH];
   logic [31:0] rdData_d;

   // Per-word next value
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SCRATCH; gi++) begin : g_word
         always_comb begin
            word_d[gi] = word_q[gi];
            if (wrEn && wrSel == 2'(gi)) begin
               word_d[gi] = wrData;
            end
         end
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               word_q[gi] <= WORD_RESET;
            end else begin
               word_q[gi] <= word_d[gi];
            end
         end
      end
   endgenerate

   // Registered read port
   assign rdData_d = word_q[rdSel];
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= WORD_RESET;
      end else begin
         rdData <= rdData_d;
      end
   end
endmodule // scratch_regs

/* pkg/exc_entry_pkg.sv */
// Constants, types and field layout for the exception entry control block.
// Assumes a 32-bit core with one core clock and an asynchronous reset.
// Function
// - Each enable mask bit gates the interrupt level with the same number.
// - After reset all interrupts stay disabled until enabled; other exceptions are still taken.
// - Interrupts are recognised only while the external enable bit is set.
// - Any write to the enable shortcut sets external enable and recoverable.
// - Entry saves the next instruction address into the saved return address.
// - Entry copies the old machine state into the saved machine state first.
// - Entry clears the external enable bit.
// - Entry clears the problem state bit, giving supervisor privilege.
// - Entry clears the recoverable bit.
// - After saving state, fetch is redirected to the exception vector.
// - Every new exception overwrites saved address and state unconditionally.
// - Only interrupts are masked by external enable; others always taken.
// - Some exception types also update fault address and fault cause.
// - Four scratch words are provided for handler software.
// - All controller interrupts share vector offset 0x00500 from the base.
// - Active level view is pending levels AND the level enable mask.
// - Any write to the recoverable-only register sets recoverable, enable 0.
// - Any write to the unrecoverable register clears the recoverable bit.
package exc_entry_pkg;
   localparam int XLEN = 32;
   localparam int NUM_LEVELS = 32;
   localparam int NUM_SCRATCH = 4;
   // Machine state bit positions
   localparam int MS_EXTEN_POS = 15;
   localparam int MS_PROB_POS = 14;
   localparam int MS_IP_POS = 6;
   localparam int MS_RECOV_POS = 1;
   // Reset values
   localparam logic [31:0] MS_RESET = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   // Vector addressing
   localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
   localparam logic [31:0] VEC_BASE_HIGH = 32'hfff0_0000;
   localparam logic [31:0] VEC_OFS_INTR = 32'h0000_0500;

   // Shortcut special register writes from the pipeline
   typedef struct packed {
      logic enableWr;     // Sets ext enable and recoverable
      logic recovOnlyWr;  // Sets recoverable, ext enable to zero
      logic unrecovWr;    // Clears recoverable
   } shortcut_t;

   // Non-interrupt exception request from the pipeline
   typedef struct packed {
      logic        valid;     // Exception taken this cycle
      logic [31:0] vecOfs;    // Vector offset of this exception
      logic        faultUpd;  // Updates fault address and cause
      logic [31:0] faultAddr;
      logic [31:0] faultCause;
   } exc_req_t;

   // Redirect to the fetch unit
   typedef struct packed {
      logic        valid;
      logic [31:0] target;
   } redirect_t;

   typedef enum logic [0:0] {
      EXC_NONE = 1'b0,
      EXC_INTR = 1'b1
   } exc_kind_t;
endpackage

/* tb/core_partner.sv */
// Partner model: pending levels of the controller and a fetch stream.
// Assumes raise and clear are driven just after the clock edge.
`timescale 1ns/1ps
module core_partner
   import exc_entry_pkg::*;
(
   input wire logic mclk, // Core clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [31:0] raise, // Levels to set
   input wire logic [31:0] clear, // Levels to clear
   input wire exc_entry_pkg::redirect_t redirect, // Fetch redirect
   output logic [31:0] pendingLevels, // Pending level bits
   output logic [31:0] nextPc // Next instruction address
);
   // Levels stay pending until cleared, as a handler must do by hand
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pendingLevels <= 32'h0;
         nextPc <= 32'h100;
      end else begin
         pendingLevels <= (pendingLevels & ~clear) | raise;
         nextPc <= redirect.valid ? redirect.target : nextPc + 32'h4;
      end
   end
endmodule // core_partner

/* tb/exc_entry_ctrl_chk.sv */
// Checker for exc_entry_ctrl, watching its ports only.
// Assumes one core clock and the active low asynchronous reset.
`timescale 1ns/1ps
module exc_entry_ctrl_chk
   import exc_entry_pkg::*;
(
   input wire logic mclk, arst_n, maskWr, msWr, rfi, intTaken, // Controls
   input wire logic extIntEnable, recoverable, // State bits
   input wire logic [31:0] pendingLevels, maskWrData, nextPc, // Inputs
   input wire logic [31:0] levelEnableMask, activeLevelView, // Mask side
   input wire logic [31:0] machineState, savedReturnAddr, // State side
   input wire logic [31:0] savedMachineState, // Saved state
   input wire exc_entry_pkg::shortcut_t shortcut, // Shortcut writes
   input wire exc_entry_pkg::exc_req_t excReq, // Other exceptions
   input wire exc_entry_pkg::redirect_t redirect // Fetch redirect
);
   logic entry, quiet;
   logic [31:0] base, excTgt;
   // Entry beats software writes, so shortcut checks need a quiet cycle
   assign entry = intTaken | excReq.valid;
   assign quiet = !entry && !rfi && !msWr;
   assign base = machineState[MS_IP_POS] ? VEC_BASE_HIGH : VEC_BASE_LOW;
   assign excTgt = base | excReq.vecOfs;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_MASK: assert property (maskWr |=> levelEnableMask == $past(maskWrData))
      else $error("mask load mismatch");
   AST_VIEW: assert property (activeLevelView == (pendingLevels & levelEnableMask))
      else $error("active view mismatch");
   AST_MASKED: assert property (!extIntEnable |-> !intTaken)
      else $error("interrupt taken while disabled");
   AST_RAISE: assert property (extIntEnable && |activeLevelView && !excReq.valid
      |-> intTaken)
      else $error("enabled interrupt not taken");
   AST_SAVE: assert property (entry |=> savedReturnAddr == $past(nextPc)
      && savedMachineState == $past(machineState))
      else $error("saved context mismatch");
   AST_CLEAR: assert property (entry |=> !extIntEnable && !recoverable
      && !machineState[MS_PROB_POS])
      else $error("state bits not cleared on entry");
   AST_VEC: assert property (intTaken && !excReq.valid |=> redirect.valid
      && redirect.target == ($past(base) | VEC_OFS_INTR))
      else $error("interrupt vector mismatch");
   AST_EXC: assert property (excReq.valid |=> redirect.valid
      && redirect.target == $past(excTgt))
      else $error("exception vector mismatch");
   AST_RET: assert property (rfi && !entry
      |=> machineState == $past(savedMachineState))
      else $error("return state mismatch");
   AST_ENSC: assert property (shortcut.enableWr && quiet |=> extIntEnable
      && recoverable)
      else $error("enable shortcut failed");
   AST_RECSC: assert property (shortcut == 3'b010 && quiet |=> recoverable
      && !extIntEnable)
      else $error("recoverable-only shortcut failed");
   AST_UNRSC: assert property (shortcut == 3'b001 && quiet |=> !recoverable)
      else $error("unrecoverable shortcut failed");
   cover property (intTaken);
   cover property (excReq.valid ##1 excReq.valid);
   cover property (shortcut.recovOnlyWr);
endmodule // exc_entry_ctrl_chk
bind exc_entry_ctrl exc_entry_ctrl_chk chk_inst (.*);

/* tb/exc_entry_ctrl_tb.sv */
// Bench for exc_entry_ctrl: drives the pipeline side, scoreboards entries.
// Assumes core_partner supplies pending levels and the next address.
`timescale 1ns/1ps
module exc_entry_ctrl_tb;
   import exc_entry_pkg::*;
   typedef struct packed {logic [31:0] tgt, ms;} exp_t;
   logic mclk = 0, arst_n = 0, maskWr = 0, msWr = 0, rfi = 0, scrWr = 0;
   logic intTaken, extIntEnable, recoverable;
   logic [1:0] scrWrSel = 0, scrRdSel = 0;
   logic [31:0] raise = 0, clear = 0, maskWrData = 0, msWrData = 0, v, s;
   logic [31:0] scrWrData = 0, pendingLevels, nextPc, scrRdData, lastPc;
   logic [31:0] levelEnableMask, activeLevelView, machineState, faultCause;
   logic [31:0] savedReturnAddr, savedMachineState, dataFaultAddr, w[4];
   shortcut_t shortcut = '0;
   exc_req_t excReq = '0;
   redirect_t redirect;
   exp_t expQ[$], e;
   int n_errors = 0, n_checks = 0, cyc = 0, seed = 32'hc80f;
   exc_entry_ctrl exc_entry_ctrl_inst (.*);
   core_partner core_partner_inst (.*);
   always #4 mclk = ~mclk;
   task step(int n = 1); repeat (n) @(posedge mclk); #1; endtask
   task chk(string nm, logic [31:0] x, logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Each redirect pops the oldest expected entry
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         print_verdict;
      end
      if (redirect.valid === 1'b1) begin
         e = expQ.pop_front();
         chk("target", e.tgt, redirect.target);
         chk("savedMs", e.ms, savedMachineState);
         chk("savedPc", lastPc, savedReturnAddr);
      end
      lastPc <= nextPc;
   end
   initial begin
      step(2);
      arst_n = 1;
      step;
      chk("state", 32'h0, machineState);
      chk("mask", 32'h0, levelEnableMask);
      raise = $random(seed) | 32'h4;
      maskWr = 1;
      maskWrData = 32'h4;
      v = ($random(seed) & ~32'h8042) | 32'h4000;
      msWrData = v;
      msWr = 1;
      step;
      {raise, maskWr, msWr} = '0;
      chk("mask", 32'h4, levelEnableMask);
      chk("view", pendingLevels & 32'h4, activeLevelView);
      step(2);
      chk("taken", 32'h0, intTaken);
      expQ.push_back('{VEC_OFS_INTR, v | 32'h8002});
      shortcut = 3'b100;
      step;
      shortcut = 0;
      step(2);
      chk("state", v & ~32'h4000, machineState);
      shortcut = 3'b010;
      step;
      chk("recov", 32'h1, recoverable);
      chk("extEn", 32'h0, extIntEnable);
      shortcut = 3'b001;
      step;
      chk("recov", 32'h0, recoverable);
      // Exceptions ignore the enable bit; the second overwrites the first
      clear = '1;
      shortcut = 3'b100;
      step;
      {clear, shortcut} = '0;
      s = (v & ~32'h4000) | 32'h8002;
      expQ.push_back('{32'h600, s});
      excReq = '{1'b1, 32'h600, 1'b1, v, ~v};
      step;
      expQ.push_back('{32'h700, s & ~32'h8002});
      excReq = '{1'b1, 32'h700, 1'b1, ~v, v};
      step;
      excReq = '0;
      chk("faultAddr", ~v, dataFaultAddr);
      chk("cause", v, faultCause);
      expQ.push_back('{32'hfff00500, 32'h8040});
      msWrData = 32'h8040;
      msWr = 1;
      raise = 32'h4;
      step;
      {msWr, raise} = '0;
      step(3);
      // Return restores the saved state; pending cleared so no re-entry
      clear = '1;
      rfi = 1;
      step;
      {clear, rfi} = '0;
      chk("retState", 32'h8040, machineState);
      foreach (w[i]) begin
         w[i] = $random(seed);
         {scrWr, scrWrSel, scrWrData} = {1'b1, 2'(i), w[i]};
         step;
      end
      scrWr = 0;
      foreach (w[i]) begin
         scrRdSel = 2'(i);
         step;
         chk("scratch", w[i], scrRdData);
      end
      chk("queue", 32'h0, 32'(expQ.size()));
      print_verdict;
   end
endmodule // exc_entry_ctrl_tb
